// File: dstp_top.sv
// Purpose: Debug status and trace port with serial debug shifter.
// Assumes: clk is the processor clock; trace_clk clocks the trace pins.
// Notes: Trace words cross by a req/ack toggle handshake.
`timescale 1ns/1ps
`include "dstp_cfg.svh"

// Functional notes
// - Summary output is AND of status bits.
// - Strobe rises mid-way through each data window.
// - Disable freezes strobe and trace, not triggers.
// - Clearing disable restarts trace; observer resynchronises.
// - Strobe idle until first C, D, F status.
// - Serial input synchronised, taken after clock high.
// - Serial output registered, updated after clock high.
// - Status follows traced core words, updated on the trace clock.
// - Data nibble carries core_data only; breakpoints go to breakpoint_trigger.
module dstp_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic trace_clk,
  input wire logic core_valid,
  input wire dstp_pkg::dstp_nib_t core_status,
  input wire dstp_pkg::dstp_nib_t core_data,
  input wire logic core_breakpoint,
  input wire logic status_clock_disable,
  input wire logic debug_serial_in,
  input wire logic debug_serial_clock,
  input wire dstp_pkg::dstp_ser_t ser_tx_word,
  output logic core_ready,
  output logic breakpoint_trigger,
  output dstp_pkg::dstp_ser_t ser_rx_word,
  output logic ser_rx_valid,
  output logic debug_serial_out,
  output dstp_pkg::dstp_nib_t processor_status,
  output dstp_pkg::dstp_nib_t debug_data_nibble,
  output logic all_status_and,
  output logic status_strobe_clock
);
  import dstp_pkg::*;

  // ------------------------------------------------------------
  // Trace word buffer
  // ------------------------------------------------------------
  dstp_word_if bif ();

  dstp_buf u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .bif(bif)
  );

  assign core_ready = bif.in_ready;

  // ------------------------------------------------------------
  // Intake: start detection and forwarding
  // ------------------------------------------------------------
  logic started_r;
  logic started_nxt;
  logic start_code;
  logic fwd_en;

  always_comb begin
    start_code = dstp_is_start(core_status);
    started_nxt = started_r;
    if (core_valid && bif.in_ready && start_code) begin
      started_nxt = 1'b1;
    end
    // Words before the start code, or while frozen, are taken and dropped
    fwd_en = (started_r || start_code) && !status_clock_disable;
    bif.in_valid = core_valid && fwd_en;
    bif.in_word.status = core_status;
    bif.in_word.data = core_data;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      started_r <= 1'b0;
    end else begin
      started_r <= started_nxt;
    end
  end

  // ------------------------------------------------------------
  // Breakpoint trigger
  // ------------------------------------------------------------
  logic trig_r;
  logic trig_nxt;

  always_comb begin
    // Triggers keep working while the trace is frozen
    trig_nxt = core_breakpoint;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  assign breakpoint_trigger = trig_r;

  // ------------------------------------------------------------
  // Handshake, processor side
  // ------------------------------------------------------------
  dstp_word_s hold_r;
  dstp_word_s hold_nxt;
  logic req_r;
  logic req_nxt;
  logic pend_r;
  logic pend_nxt;
  logic load;
  logic ack_s;
  logic seen_r;

  dstp_sync #(.W(1)) u_ack_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(seen_r),
    .q(ack_s)
  );

  always_comb begin
    hold_nxt = hold_r;
    req_nxt = req_r;
    pend_nxt = pend_r;
    load = bif.out_valid && !pend_r && !status_clock_disable;
    // While frozen the buffer drains into nothing, so the core stalls for at most the first frozen cycle
    bif.out_ready = !pend_r || status_clock_disable;
    if (pend_r && (ack_s == req_r)) begin
      pend_nxt = 1'b0;
    end
    if (load) begin
      hold_nxt = bif.out_word;
      req_nxt = !req_r;
      pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= '0;
      req_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      req_r <= req_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ------------------------------------------------------------
  // Serial debug shifter
  // ------------------------------------------------------------
  logic [1:0] ser_pins_s;
  logic sclk_prev_r;
  logic sclk_prev_nxt;
  logic sclk_rise;
  logic [`DSTP_BITCNT_W-1:0] bit_cnt_r;
  logic [`DSTP_BITCNT_W-1:0] bit_cnt_nxt;
  dstp_ser_t rx_sh_r;
  dstp_ser_t rx_sh_nxt;
  dstp_ser_t tx_sh_r;
  dstp_ser_t tx_sh_nxt;
  dstp_ser_t tx_src;
  dstp_ser_t rx_word_r;
  dstp_ser_t rx_word_nxt;
  logic rx_valid_r;
  logic rx_valid_nxt;
  logic sout_r;
  logic sout_nxt;

  dstp_sync #(.W(2)) u_ser_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({debug_serial_clock, debug_serial_in}),
    .q(ser_pins_s)
  );

  always_comb begin
    sclk_prev_nxt = ser_pins_s[1];
    sclk_rise = ser_pins_s[1] && !sclk_prev_r;
    // Idle between frames, the next word is sampled live
    tx_src = (bit_cnt_r == '0) ? ser_tx_word : tx_sh_r;
    bit_cnt_nxt = bit_cnt_r;
    rx_sh_nxt = rx_sh_r;
    tx_sh_nxt = tx_sh_r;
    rx_word_nxt = rx_word_r;
    rx_valid_nxt = 1'b0;
    sout_nxt = sout_r;
    if (sclk_rise) begin
      rx_sh_nxt = {rx_sh_r[`DSTP_SER_W-2:0], ser_pins_s[0]};
      sout_nxt = tx_src[`DSTP_SER_W-1];
      tx_sh_nxt = {tx_src[`DSTP_SER_W-2:0], 1'b0};
      bit_cnt_nxt = bit_cnt_r + 1'b1;
      if (bit_cnt_r == `DSTP_BITCNT_LAST) begin
        rx_word_nxt = rx_sh_nxt;
        rx_valid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_r <= 1'b0;
      bit_cnt_r <= '0;
      rx_sh_r <= `DSTP_SER_RST;
      tx_sh_r <= `DSTP_SER_RST;
      rx_word_r <= `DSTP_SER_RST;
      rx_valid_r <= 1'b0;
      sout_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_prev_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_sh_r <= tx_sh_nxt;
      rx_word_r <= rx_word_nxt;
      rx_valid_r <= rx_valid_nxt;
      sout_r <= sout_nxt;
    end
  end

  assign ser_rx_word = rx_word_r;
  assign ser_rx_valid = rx_valid_r;
  assign debug_serial_out = sout_r;

  // ------------------------------------------------------------
  // Trace clock reset release
  // ------------------------------------------------------------
  logic trst_meta_r;
  logic trst_meta_nxt;
  logic trst_b_r;
  logic trst_b_nxt;

  always_comb begin
    trst_meta_nxt = 1'b1;
    trst_b_nxt = trst_meta_r;
  end

  // Assert at once, release two trace edges later
  always_ff @(posedge trace_clk or negedge rst_b) begin
    if (!rst_b) begin
      trst_meta_r <= 1'b0;
      trst_b_r <= 1'b0;
    end else begin
      trst_meta_r <= trst_meta_nxt;
      trst_b_r <= trst_b_nxt;
    end
  end

  // ------------------------------------------------------------
  // Trace pin sequencer
  // ------------------------------------------------------------
  logic [1:0] tr_s;
  logic tdis;
  logic fresh;
  logic seen_nxt;
  logic strobe_r;
  logic strobe_nxt;
  logic allp_r;
  logic allp_nxt;
  dstp_word_s tword_r;
  dstp_word_s tword_nxt;
  dstp_trace_e tstate_r;
  dstp_trace_e tstate_nxt;

  dstp_sync #(.W(2)) u_trace_sync (
    .clk(trace_clk),
    .rst_b(trst_b_r),
    .d({status_clock_disable, req_r}),
    .q(tr_s)
  );

  always_comb begin
    tdis = tr_s[1];
    fresh = (tr_s[0] != seen_r);
    tstate_nxt = tstate_r;
    strobe_nxt = strobe_r;
    seen_nxt = seen_r;
    tword_nxt = tword_r;
    allp_nxt = allp_r;
    unique case (tstate_r)
      TR_IDLE: begin
        // Strobe parked low until a word arrives and the port is enabled
        strobe_nxt = 1'b0;
        if (fresh && !tdis) begin
          tword_nxt = hold_r;
          allp_nxt = &hold_r.status;
          seen_nxt = tr_s[0];
          tstate_nxt = TR_SETUP;
        end
      end
      TR_SETUP: begin
        // Data changed one trace edge ago, so the rise lands mid-window
        strobe_nxt = 1'b1;
        tstate_nxt = TR_STROBE;
      end
      TR_STROBE: begin
        strobe_nxt = 1'b0;
        if (tdis) begin
          tstate_nxt = TR_IDLE;
        end else begin
          // Without a fresh word the last one repeats; the strobe keeps running
          if (fresh) begin
            tword_nxt = hold_r;
            allp_nxt = &hold_r.status;
            seen_nxt = tr_s[0];
          end
          tstate_nxt = TR_SETUP;
        end
      end
      default: begin
        strobe_nxt = 1'b0;
        tstate_nxt = TR_IDLE;
      end
    endcase
  end

  always_ff @(posedge trace_clk or negedge trst_b_r) begin
    if (!trst_b_r) begin
      tstate_r <= TR_IDLE;
      strobe_r <= 1'b0;
      seen_r <= 1'b0;
      tword_r <= '0;
      allp_r <= 1'b0;
    end else begin
      tstate_r <= tstate_nxt;
      strobe_r <= strobe_nxt;
      seen_r <= seen_nxt;
      tword_r <= tword_nxt;
      allp_r <= allp_nxt;
    end
  end

  assign processor_status = tword_r.status;
  assign debug_data_nibble = tword_r.data;
  assign all_status_and = allp_r;
  assign status_strobe_clock = strobe_r;
endmodule

// File: dstp_cfg.svh
// Purpose: Constants of the debug status and trace port.
// Assumes: Included by the package and by the dstp_top and dstp_buf files.
// Notes: Guarded against double inclusion.
`ifndef DSTP_CFG_SVH
`define DSTP_CFG_SVH
`define DSTP_NIB_W 4
`define DSTP_SER_W 8
`define DSTP_BITCNT_W 3
`define DSTP_BITCNT_LAST 3'h7
`define DSTP_BUF_DEPTH 2
`define DSTP_BUF_FULL 2'h2
`define DSTP_PST_START_C 4'hC
`define DSTP_PST_START_D 4'hD
`define DSTP_PST_START_F 4'hF
`define DSTP_NIB_RST 4'h0
`define DSTP_SER_RST 8'h00
`endif

// File: dstp_pkg.sv
// Purpose: Types of the debug status and trace port.
// Assumes: dstp_cfg.svh holds the numbers.
// Notes: Start-code decode lives here for reuse.
`include "dstp_cfg.svh"

package dstp_pkg;
  typedef logic [`DSTP_NIB_W-1:0] dstp_nib_t;
  typedef logic [`DSTP_SER_W-1:0] dstp_ser_t;
  typedef struct packed {
    dstp_nib_t status;
    dstp_nib_t data;
  } dstp_word_s;
  typedef enum logic [2:0] {
    TR_IDLE = 3'b001,
    TR_SETUP = 3'b010,
    TR_STROBE = 3'b100
  } dstp_trace_e;

  function automatic logic dstp_is_start(input dstp_nib_t s);
    return (s == `DSTP_PST_START_C) || (s == `DSTP_PST_START_D) || (s == `DSTP_PST_START_F);
  endfunction
endpackage

// File: dstp_word_if.sv
// Purpose: Trace word path between the port logic and its buffer.
// Assumes: Both sides on the processor clock.
// Notes: Valid/ready on both the filling and the draining side.
`timescale 1ns/1ps

interface dstp_word_if;
  import dstp_pkg::*;
  logic in_valid;
  logic in_ready;
  dstp_word_s in_word;
  logic out_valid;
  logic out_ready;
  dstp_word_s out_word;

  modport buf_mp (input in_valid, input in_word, input out_ready,
                  output in_ready, output out_valid, output out_word);
  modport user_mp (output in_valid, output in_word, output out_ready,
                   input in_ready, input out_valid, input out_word);
endinterface

// File: dstp_sync.sv
// Purpose: Two-flop level synchroniser.
// Assumes: d is asynchronous to clk.
// Notes: Only the second stage may be read.
`timescale 1ns/1ps

module dstp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// File: dstp_buf.sv
// Purpose: Two-entry trace word buffer.
// Assumes: Single clock domain.
// Notes: Ready is a flop, so the core sees a clean stall.
`timescale 1ns/1ps
`include "dstp_cfg.svh"

module dstp_buf (
  input wire logic clk,
  input wire logic rst_b,
  dstp_word_if.buf_mp bif
);
  import dstp_pkg::*;

  dstp_word_s mem_r [`DSTP_BUF_DEPTH];
  dstp_word_s mem_nxt [`DSTP_BUF_DEPTH];
  logic wr_r, wr_nxt, rd_r, rd_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt, push, pop;

  assign bif.in_ready = rdy_r;
  assign bif.out_valid = (cnt_r != 2'h0);
  assign bif.out_word = mem_r[rd_r];

  always_comb begin
    mem_nxt = mem_r;
    push = bif.in_valid && rdy_r;
    pop = (cnt_r != 2'h0) && bif.out_ready;
    wr_nxt = push ? !wr_r : wr_r;
    rd_nxt = pop ? !rd_r : rd_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    if (push) begin
      mem_nxt[wr_r] = bif.in_word;
    end
    rdy_nxt = (cnt_nxt != `DSTP_BUF_FULL);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_r <= '{default: '0};
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      cnt_r <= 2'h0;
      rdy_r <= 1'b1;
    end else begin
      mem_r <= mem_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end
endmodule

// File: dstp_top_chk.sv
// Purpose: Port assertions for dstp_top.
// Assumes: Bound to every dstp_top instance.
// Notes: Serial rises are counted from raw pin samples.
`timescale 1ns/1ps

module dstp_top_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic trace_clk,
  input wire logic core_valid,
  input wire dstp_pkg::dstp_nib_t core_status,
  input wire logic core_ready,
  input wire logic core_breakpoint,
  input wire logic breakpoint_trigger,
  input wire logic status_clock_disable,
  input wire logic debug_serial_clock,
  input wire logic debug_serial_out,
  input wire dstp_pkg::dstp_ser_t ser_rx_word,
  input wire logic ser_rx_valid,
  input wire dstp_pkg::dstp_nib_t processor_status,
  input wire dstp_pkg::dstp_nib_t debug_data_nibble,
  input wire logic all_status_and,
  input wire logic status_strobe_clock
);
  import dstp_pkg::*;
  logic start_r, start_nxt, sclk_r, sclk_nxt;
  logic [3:0] dis_r, dis_nxt, rise_r, rise_nxt;

  always_comb begin
    start_nxt = start_r | (core_valid & core_ready & (core_status == 4'hC || core_status == 4'hD || core_status == 4'hF));
    dis_nxt = !status_clock_disable ? 4'h0 : (dis_r == 4'hF ? dis_r : dis_r + 4'h1);
    sclk_nxt = debug_serial_clock;
    rise_nxt = (ser_rx_valid ? 4'h0 : rise_r) + {3'h0, debug_serial_clock & !sclk_r};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_r <= 1'b0;
      sclk_r <= 1'b0;
      dis_r <= 4'h0;
      rise_r <= 4'h0;
    end else begin
      start_r <= start_nxt;
      sclk_r <= sclk_nxt;
      dis_r <= dis_nxt;
      rise_r <= rise_nxt;
    end
  end

  // ----
  // Trace domain
  // ----
  property p_and;
    @(posedge trace_clk) disable iff (!rst_b) all_status_and == &processor_status;
  endproperty
  a_and: assert property (p_and) else $error("summary bit wrong");
  property p_rise_mid;
    @(posedge trace_clk) disable iff (!rst_b)
      $rose(status_strobe_clock) |-> $stable(processor_status) && $stable(debug_data_nibble);
  endproperty
  a_rise_mid: assert property (p_rise_mid) else $error("data moved at strobe rise");
  property p_chg_low;
    @(posedge trace_clk) disable iff (!rst_b) !$stable(processor_status) |-> !status_strobe_clock;
  endproperty
  a_chg_low: assert property (p_chg_low) else $error("status moved with strobe high");
  property p_half;
    @(posedge trace_clk) disable iff (!rst_b) $rose(status_strobe_clock) |=> $fell(status_strobe_clock);
  endproperty
  a_half: assert property (p_half) else $error("strobe high too long");
  property p_idle;
    @(posedge trace_clk) disable iff (!rst_b) status_strobe_clock |-> start_r;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe before start code");
  property p_freeze;
    @(posedge trace_clk) disable iff (!rst_b) dis_r == 4'hF |->
      !status_strobe_clock && $stable(processor_status) && $stable(debug_data_nibble);
  endproperty
  a_freeze: assert property (p_freeze) else $error("trace moves while disabled");

  // ----
  // Processor clock domain
  // ----
  property p_trig;
    @(posedge clk) disable iff (!rst_b) status_clock_disable |=> breakpoint_trigger == $past(core_breakpoint);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger lost while disabled");
  property p_sout;
    @(posedge clk) disable iff (!rst_b)
      !$stable(debug_serial_out) |-> $past(debug_serial_clock) && $past(debug_serial_clock, 2);
  endproperty
  a_sout: assert property (p_sout) else $error("serial out moved without clock high");
  property p_rxw;
    @(posedge clk) disable iff (!rst_b) !$stable(ser_rx_word) |-> ser_rx_valid;
  endproperty
  a_rxw: assert property (p_rxw) else $error("rx word moved without valid");
  property p_rxv;
    @(posedge clk) disable iff (!rst_b) ser_rx_valid |-> rise_r == 4'h8 ##1 !ser_rx_valid;
  endproperty
  a_rxv: assert property (p_rxv) else $error("rx valid not after eight rises");
endmodule

bind dstp_top dstp_top_chk u_dstp_top_chk (.clk, .rst_b, .trace_clk, .core_valid, .core_status, .core_ready,
  .core_breakpoint, .breakpoint_trigger, .status_clock_disable, .debug_serial_clock, .debug_serial_out,
  .ser_rx_word, .ser_rx_valid, .processor_status, .debug_data_nibble, .all_status_and, .status_strobe_clock);

// File: dstp_host.sv
// Purpose: Development system model.
// Assumes: Serial clock high and low 200 ns each.
// Notes: Serial clock stands low between frames.
`timescale 1ns/1ps

module dstp_host (
  input wire logic status_strobe_clock,
  input wire dstp_pkg::dstp_nib_t processor_status,
  input wire dstp_pkg::dstp_nib_t debug_data_nibble,
  input wire logic debug_serial_out,
  output logic debug_serial_clock,
  output logic debug_serial_in
);
  import dstp_pkg::*;
  dstp_word_s cap_q[$];

  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b0;
  end

  // Relocks on the strobe alone, so a restart needs no extra step
  always @(posedge status_strobe_clock) cap_q.push_back({processor_status, debug_data_nibble});

  task automatic xfer(input dstp_ser_t tx, output dstp_ser_t rx);
    for (int i = 7; i >= 0; i--) begin
      debug_serial_in = tx[i];
      #200 debug_serial_clock = 1'b1;
      #195 rx[i] = debug_serial_out;
      #5 debug_serial_clock = 1'b0;
    end
    // Released line shows the inverse, not a stale bit
    debug_serial_in = !tx[0];
  endtask
endmodule

// File: dstp_top_tb.sv
// Purpose: Self-checking bench for dstp_top.
// Assumes: dstp_host stands for the development system.
// Notes: Trace stream compared after folding repeats.
`timescale 1ns/1ps

module dstp_top_tb;
  import dstp_pkg::*;
  logic clk, rst_b, trace_clk, core_valid, core_breakpoint, status_clock_disable, debug_serial_in;
  logic core_ready, breakpoint_trigger, ser_rx_valid, debug_serial_out, all_status_and, status_strobe_clock;
  logic debug_serial_clock;
  dstp_nib_t core_status, core_data, processor_status, debug_data_nibble;
  dstp_ser_t ser_tx_word, ser_rx_word, host_rx, host_tx;
  dstp_nib_t starts[3] = '{4'hC, 4'hD, 4'hF};
  dstp_word_s exp_q[$];
  dstp_word_s w;
  int failures, tests_run, cycles, n_before;
  bit started_m, saw_stall, bp_exp, bp_armed;

  dstp_top u_dstp_top (.clk, .rst_b, .trace_clk, .core_valid, .core_status, .core_data, .core_breakpoint,
    .status_clock_disable, .debug_serial_in, .debug_serial_clock, .ser_tx_word, .core_ready,
    .breakpoint_trigger, .ser_rx_word, .ser_rx_valid, .debug_serial_out, .processor_status,
    .debug_data_nibble, .all_status_and, .status_strobe_clock);
  dstp_host u_dstp_host (.status_strobe_clock, .processor_status, .debug_data_nibble, .debug_serial_out,
    .debug_serial_clock, .debug_serial_in);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    trace_clk = 1'b0;
    #7;
    forever #32 trace_clk = ~trace_clk;
  end
  always @(posedge clk) begin
    cycles++;
    // Value the design samples at this edge, before the bench moves it
    bp_exp <= core_breakpoint;
    bp_armed <= rst_b;
    core_breakpoint <= #1 1'($urandom);
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  // Trigger looked at mid-cycle, away from the edge that launches it
  always @(negedge clk) if (rst_b && bp_armed) check("trigger", {15'h0, breakpoint_trigger}, {15'h0, bp_exp});

  task automatic summarize;
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    step(10);
    rst_b = 1'b1;
    exp_q.delete();
    u_dstp_host.cap_q.delete();
    started_m = 0;
    step(1);
    check("reset", {core_ready, status_strobe_clock, all_status_and, processor_status, debug_data_nibble,
      ser_rx_valid}, {4'h0, 1'b1, 11'h0});
  endtask
  // Model: words count only once a start code was taken and trace is on
  task automatic offer(input dstp_nib_t s);
    do w = dstp_word_s'({s, 4'($urandom)}); while (exp_q.size() > 0 && w === exp_q[$]);
    core_status = w.status;
    core_data = w.data;
    while (core_ready !== 1'b1) begin
      saw_stall = 1;
      step(1);
    end
    started_m = started_m | (s == 4'hC || s == 4'hD || s == 4'hF);
    if (started_m && !status_clock_disable) exp_q.push_back(w);
    step(1);
  endtask
  task automatic burst(input int n);
    core_valid = 1'b1;
    repeat (n) offer(4'($urandom));
    core_valid = 1'b0;
    step(40);
  endtask
  task automatic compare_trace;
    dstp_word_s got[$];
    foreach (u_dstp_host.cap_q[i])
      if (got.size() == 0 || got[$] !== u_dstp_host.cap_q[i]) got.push_back(u_dstp_host.cap_q[i]);
    check("trace_count", 16'(got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) check("trace_word", 16'(got[i]), 16'(exp_q[i]));
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    rst_b = 1'b0;
    core_valid = 1'b0;
    core_status = 4'h0;
    core_data = 4'h0;
    core_breakpoint = 1'b0;
    status_clock_disable = 1'b0;
    ser_tx_word = 8'h00;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    saw_stall = 0;
    void'($urandom(42132));
    for (int k = 0; k < 3; k++) begin
      do_reset();
      core_valid = 1'b1;
      offer(4'h1);
      offer(4'hB);
      core_valid = 1'b0;
      step(20);
      check("idle_strobe", 16'(u_dstp_host.cap_q.size()), 16'h0);
      core_valid = 1'b1;
      offer(starts[k]);
      burst(10);
      if (k == 1) begin
        status_clock_disable = 1'b1;
        step(20);
        n_before = u_dstp_host.cap_q.size();
        burst(4);
        check("frozen", 16'(u_dstp_host.cap_q.size()), 16'(n_before));
        status_clock_disable = 1'b0;
        step(10);
        burst(6);
      end
      compare_trace();
    end
    check("stall", {15'h0, saw_stall}, 16'h1);
    repeat (3) begin
      ser_tx_word = 8'($urandom);
      host_tx = 8'($urandom);
      u_dstp_host.xfer(host_tx, host_rx);
      step(4);
      check("ser_rx", {8'h0, ser_rx_word}, {8'h0, host_tx});
      check("ser_tx", {8'h0, host_rx}, {8'h0, ser_tx_word});
    end
    summarize();
  end
endmodule
